// ---- verilog/qec_counter.sv ----
// What this block does
// - Pulse output enabled: toggle output pin on every overflow and underflow.
// - Count direction comes from the phase relation of the two pulses.
// - Overflow or underflow copies reload register into counter, counting goes on.
// - Free-run selected: no reload, counter wraps and keeps counting.
// - Ratio is 1/(FFFF-n+1) counting up, 1/(n+1) counting down.
// - Counting runs while start flag is 1, halts when cleared to 0.
// - Every overflow or underflow sets a status bit; it raises an interrupt request only if its mask bit is set.
// - Reading the timer register returns the current count.
// - Write while stopped loads both reload register and counter.
// - Write while running loads only reload register, counter at next reload.
// - Normal: with B high, A rising counts up, A falling counts down.
// - Times four: A rising while B high makes every edge count up.
// - Times four: A falling while B high makes every edge count down.
`default_nettype none
module qec_counter
   import qec_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock_in,
   input  wire logic              rst_n_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   input  wire logic [31:0]       s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   output logic [1:0]             s_axi_bresp_out,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   output logic [31:0]            s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   input  wire logic              timer_phase_a_in_pin_in,
   input  wire logic              timer_phase_b_out_pin_in,
   output logic                   timer_phase_b_out_pin_out,
   output logic                   timer_phase_b_out_pin_oe_out,
   output logic                   irq_out
);

   // ****************
   // State
   // ****************
   typedef struct packed {
      // Software-visible registers
      logic [QEC_CTRL_W-1:0] ctrl;
      logic [15:0]           cnt;
      logic [15:0]           rld;
      // Sticky status and its mask share one layout
      logic [QEC_EV_W-1:0]   sts;
      logic [QEC_EV_W-1:0]   msk;
      // Counter side: held direction and pulse level
      logic                  dir_up;
      logic                  pin;
      // Pin samplers: two sync stages, then a previous-value stage
      logic                  a_s1;
      logic                  a_s2;
      logic                  a_p;
      logic                  b_s1;
      logic                  b_s2;
      logic                  b_p;
      // Write channel halves, held until both have arrived
      logic                  aw_v;
      logic [ADDR_W-1:0]     aw_a;
      logic                  w_v;
      logic [31:0]           w_d;
      logic [3:0]            w_s;
      // Write response and read data, each standing until taken
      logic                  bv;
      logic [1:0]            bresp;
      logic                  rv;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } qec_state_t;

   qec_state_t s_q;
   qec_state_t s_d;
   // Internal reset copy; the pin only starts its release
   logic       rst_s1_q;
   logic       rst_s2_q;

   // Byte-lane merge for narrow registers
   // Lanes without a strobe keep their old byte; upper lanes are ignored
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [15:0] r;
      r = old;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Address decode shared by read and write paths
   // Unmapped offsets answer with an error and change nothing
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] o;
      o = 8'(a);
      return (o == QEC_CTRL_OFS) || (o == QEC_TIMER_OFS) ||
             (o == QEC_RELOAD_OFS) || (o == QEC_STATUS_OFS) ||
             (o == QEC_MASK_OFS) || (o == QEC_STATE_OFS);
   endfunction

   // ****************
   // Reset release
   // ****************
   // Async assert, sync release through two flops
   // A release close to an edge could free part of the state a cycle early;
   // the second flop hands every register the same release edge
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ****************
   // Next state
   // ****************
   // Decode results of this cycle, shared by the steps below
   logic        a_rise;
   logic        a_fall;
   logic        b_edge;
   logic        step;
   logic        up;
   logic        wr_go;
   logic [7:0]  wofs;
   logic [7:0]  rofs;
   logic [QEC_EV_W-1:0] ev;

   always_comb begin
      // Everything holds unless a step below changes it
      s_d    = s_q;
      ev     = '0;
      step   = 1'b0;
      up     = s_q.dir_up;
      wofs   = 8'(s_q.aw_a);
      rofs   = 8'(s_axi_araddr_in);
      wr_go  = s_q.aw_v && s_q.w_v && !s_q.bv;

      // ****************
      // Pin sampling
      // ****************
      // Two-flop sync, then edge detect on the second stage only
      // A pin moving near an edge settles in the first stage before any use
      // Samplers reset low, so a pin resting high shows one false edge;
      // counting is off then, since the start flag resets to zero
      s_d.a_s1 = timer_phase_a_in_pin_in;
      s_d.a_s2 = s_q.a_s1;
      s_d.a_p  = s_q.a_s2;
      s_d.b_s1 = timer_phase_b_out_pin_in;
      s_d.b_s2 = s_q.b_s1;
      s_d.b_p  = s_q.b_s2;
      a_rise = s_q.a_s2 && !s_q.a_p;
      a_fall = !s_q.a_s2 && s_q.a_p;
      b_edge = s_q.b_s2 ^ s_q.b_p;

      // ****************
      // Direction decode
      // ****************
      // Direction decode; one step even if both pins move together
      // Times four latches direction on an A edge while B is high and holds it
      // through the other three edges; normal mode decodes the A edge alone
      // After reset the held direction is down until an A edge sets it
      if (s_q.ctrl[QEC_CTRL_X4_BIT]) begin
         if (a_rise && s_q.b_s2) begin
            up = 1'b1;
         end else if (a_fall && s_q.b_s2) begin
            up = 1'b0;
         end
         step = a_rise || a_fall || b_edge;
      end else begin
         up   = a_rise;
         step = s_q.b_s2 && (a_rise || a_fall);
      end
      s_d.dir_up = up;

      // ****************
      // Counter
      // ****************
      // Counting only while start flag is set
      // Up past all ones overflows, down past zero underflows; the reload copy
      // restarts the count unless free-run lets it wrap
      // Limitation: one step per clock at most, pins must move slower
      if (step && s_q.ctrl[QEC_CTRL_START_BIT]) begin
         if (up && s_q.cnt == QEC_COUNT_MAX) begin
            ev[QEC_EV_OVF_BIT] = 1'b1;
         end else if (!up && s_q.cnt == QEC_COUNT_RST) begin
            ev[QEC_EV_UNF_BIT] = 1'b1;
         end
         if (|ev && !s_q.ctrl[QEC_CTRL_FREE_BIT]) begin
            s_d.cnt = s_q.rld;
         end else if (up) begin
            s_d.cnt = s_q.cnt + 16'h0001;
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end

      // Output pin flips on each wrap while pulse output is on
      // Limitation: the same pin is a count input, so in times-four mode
      // each toggle comes back as one more count edge
      if (|ev && s_q.ctrl[QEC_CTRL_PULSE_BIT]) begin
         s_d.pin = !s_q.pin;
      end

      // ****************
      // Register writes
      // ****************
      // Write channel capture, either order
      // Each half waits in its own slot; the write fires once both are in
      if (s_axi_awvalid_in && !s_q.aw_v && !s_q.bv) begin
         s_d.aw_v = 1'b1;
         s_d.aw_a = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !s_q.w_v && !s_q.bv) begin
         s_d.w_v = 1'b1;
         s_d.w_d = s_axi_wdata_in;
         s_d.w_s = s_axi_wstrb_in;
      end

      // Sticky events; a new event beats a same-cycle clear
      // Software clears a bit by writing a one to it below
      // A clear that meets a new event leaves that event's bit set
      s_d.sts = s_q.sts | ev;

      // Register write once both halves are held
      // The response is decided here, so a bad offset never touches state
      // Control, timer, status and mask are the only writable offsets
      if (wr_go) begin
         s_d.aw_v  = 1'b0;
         s_d.w_v   = 1'b0;
         s_d.bv    = 1'b1;
         s_d.bresp = is_mapped(s_q.aw_a) ? QEC_RESP_OKAY : QEC_RESP_SLVERR;
         if (wofs == QEC_CTRL_OFS && s_q.w_s[0]) begin
            s_d.ctrl = s_q.w_d[QEC_CTRL_W-1:0];
         end
         // Running: only the reload copy moves; the count takes it at the next reload
         if (wofs == QEC_TIMER_OFS) begin
            s_d.rld = lane_merge(s_q.rld, s_q.w_d, s_q.w_s);
            if (!s_q.ctrl[QEC_CTRL_START_BIT]) begin
               s_d.cnt = lane_merge(s_q.cnt, s_q.w_d, s_q.w_s);
            end
         end
         if (wofs == QEC_STATUS_OFS && s_q.w_s[0]) begin
            s_d.sts = (s_q.sts & ~s_q.w_d[QEC_EV_W-1:0]) | ev;
         end
         if (wofs == QEC_MASK_OFS && s_q.w_s[0]) begin
            s_d.msk = s_q.w_d[QEC_EV_W-1:0];
         end
      end
      // Response leaves once the master has taken it
      if (s_q.bv && s_axi_bready_in) begin
         s_d.bv = 1'b0;
      end

      // ****************
      // Register reads
      // ****************
      // Read path, one word per request
      // Data is captured once and stands until rready; later counts leave it
      if (s_axi_arvalid_in && !s_q.rv) begin
         s_d.rv    = 1'b1;
         s_d.rresp = is_mapped(s_axi_araddr_in) ? QEC_RESP_OKAY : QEC_RESP_SLVERR;
         s_d.rdata = 32'h0000_0000;
         unique case (rofs)
            QEC_CTRL_OFS: begin
               s_d.rdata = 32'(s_q.ctrl);
            end
            QEC_TIMER_OFS: begin
               s_d.rdata = 32'(s_q.cnt);
            end
            QEC_RELOAD_OFS: begin
               s_d.rdata = 32'(s_q.rld);
            end
            QEC_STATUS_OFS: begin
               s_d.rdata = 32'(s_q.sts);
            end
            QEC_MASK_OFS: begin
               s_d.rdata = 32'(s_q.msk);
            end
            QEC_STATE_OFS: begin
               s_d.rdata = {28'h0000000, s_q.b_s2, s_q.a_s2, s_q.pin, s_q.dir_up};
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end else if (s_q.rv && s_axi_rready_in) begin
         s_d.rv = 1'b0;
      end
   end

   // ****************
   // Registers
   // ****************
   // One bank for all state; reset brings count and reload to their start values
   // Reset reaches these through the internal copy, so all release in step
   always_ff @(posedge clock_in or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         s_q     <= '0;
         s_q.cnt <= QEC_COUNT_RST;
         s_q.rld <= QEC_RELOAD_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************
   // Outputs
   // ****************
   // Ready while nothing of that kind is held or pending
   // Handshakes come from held state only, never straight from an input
   // Both write readies stay low while the response stands
   assign s_axi_awready_out = !s_q.aw_v && !s_q.bv;
   assign s_axi_wready_out  = !s_q.w_v && !s_q.bv;
   assign s_axi_bvalid_out  = s_q.bv;
   assign s_axi_bresp_out   = s_q.bresp;
   assign s_axi_arready_out = !s_q.rv;
   assign s_axi_rvalid_out  = s_q.rv;
   assign s_axi_rdata_out   = s_q.rdata;
   assign s_axi_rresp_out   = s_q.rresp;

   // Pin driven only with pulse output; else it is a count input
   assign timer_phase_b_out_pin_out    = s_q.pin;
   assign timer_phase_b_out_pin_oe_out = s_q.ctrl[QEC_CTRL_PULSE_BIT];
   // Level interrupt: high while any unmasked status bit is set
   assign irq_out = |(s_q.sts & s_q.msk);

endmodule
`default_nettype wire

// ---- verilog/qec_pkg.sv ----
`default_nettype none
package qec_pkg;
   // ****************
   // Register map
   // ****************
   localparam logic [7:0] QEC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] QEC_TIMER_OFS  = 8'h04;
   localparam logic [7:0] QEC_RELOAD_OFS = 8'h08;
   localparam logic [7:0] QEC_STATUS_OFS = 8'h0c;
   localparam logic [7:0] QEC_MASK_OFS   = 8'h10;
   localparam logic [7:0] QEC_STATE_OFS  = 8'h14;

   // ****************
   // Control fields
   // ****************
   localparam int QEC_CTRL_START_BIT = 0;
   localparam int QEC_CTRL_FREE_BIT  = 1;
   localparam int QEC_CTRL_X4_BIT    = 2;
   localparam int QEC_CTRL_PULSE_BIT = 3;
   localparam int QEC_CTRL_W         = 4;

   // Status and mask layout
   localparam int QEC_EV_OVF_BIT = 0;
   localparam int QEC_EV_UNF_BIT = 1;
   localparam int QEC_EV_W       = 2;

   // ****************
   // Reset values and count limit
   // ****************
   localparam logic [15:0] QEC_COUNT_RST  = 16'h0000;
   localparam logic [15:0] QEC_RELOAD_RST = 16'h0000;
   localparam logic [15:0] QEC_COUNT_MAX  = 16'hffff;

   // AXI responses
   localparam logic [1:0] QEC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] QEC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- test/qec_counter_chk.sv ----
`default_nettype none
module qec_counter_chk (
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        s_axi_awready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_arready_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   input wire logic        timer_phase_a_in_pin_in,
   input wire logic        timer_phase_b_out_pin_in,
   input wire logic        timer_phase_b_out_pin_out,
   input wire logic        timer_phase_b_out_pin_oe_out,
   input wire logic        irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // Pin activity age
   // ****************
   logic [3:0] quiet_q;
   logic [1:0] pins_q;
   // Counter events need a recent pin edge; saturate so the age never wraps
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         quiet_q <= 4'h0;
         pins_q  <= 2'h0;
      end else begin
         pins_q  <= {timer_phase_a_in_pin_in, timer_phase_b_out_pin_in};
         quiet_q <= (pins_q != {timer_phase_a_in_pin_in, timer_phase_b_out_pin_in}) ? 4'h0 :
                    quiet_q + {3'h0, quiet_q != 4'hf};
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence pin_event;
      quiet_q <= 4'h5;
   endsequence
   sequence wr_done;
      $rose(s_axi_bvalid_out);
   endsequence
   aw_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
      else $error("write address open during response");
   ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read address open during read data");
   rd_once_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
      else $error("read data repeated");
   wr_once_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write response repeated");
   pin_toggle_a: assert property ($changed(timer_phase_b_out_pin_out) |-> pin_event)
      else $error("pulse output moved without a count");
   irq_rise_a: assert property ($rose(irq_out) |-> quiet_q <= 4'h5 || s_axi_bvalid_out)
      else $error("interrupt rose without cause");
   irq_fall_a: assert property ($fell(irq_out) |-> s_axi_bvalid_out)
      else $error("interrupt fell without a write");
   oe_move_a: assert property ($changed(timer_phase_b_out_pin_oe_out) |-> wr_done)
      else $error("output enable moved without a write");
endmodule
bind qec_counter qec_counter_chk CHK (.*);
`default_nettype wire

// ---- test/qec_encoder.sv ----
`default_nettype none
module qec_encoder (
   input  wire logic clock_in,
   output logic      phase_a_out,
   output logic      phase_b_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Gray position; levels hold between moves, as a resting shaft does
   logic [1:0] pos_q = 2'h0;
   assign phase_a_out = pos_q[0] ^ pos_q[1];
   assign phase_b_out = ~pos_q[1];
   // One step per gap cycles; a large gap gives a slow source
   task automatic move(input int n, input bit up, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge clock_in);
         pos_q <= up ? pos_q + 2'h1 : pos_q - 2'h1;
      end
   endtask
endmodule
`default_nettype wire

// ---- test/tb_quadrature_event_counter.sv ----
`default_nettype none
module tb_quadrature_event_counter
   import qec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_in = 1'b0, rst_n_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic        s_axi_arvalid_in = 1'b0, s_axi_bready_in = 1'b0, s_axi_rready_in = 1'b0;
   logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
   logic [3:0]  s_axi_wstrb_in = 4'h0;
   logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp, wrsp;
   logic        timer_phase_a_in_pin_in, timer_phase_b_out_pin_in, enc_b, irq_out;
   logic        timer_phase_b_out_pin_out, timer_phase_b_out_pin_oe_out;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   // Shared pin: the device wins while it drives, else the source
   assign timer_phase_b_out_pin_in = timer_phase_b_out_pin_oe_out ? timer_phase_b_out_pin_out : enc_b;
   qec_counter DUT (.*);
   qec_encoder ENC (.clock_in, .phase_a_out(timer_phase_a_in_pin_in), .phase_b_out(enc_b));
   // ****************
   // Tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Leading edge keeps a lowered ready apart from the next raise
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clock_in);
      s_axi_awaddr_in  <= ad;
      s_axi_wdata_in   <= d;
      s_axi_wstrb_in   <= 4'hf;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in  <= 1'b1;
      s_axi_bready_in  <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      s_axi_bready_in <= 1'b0;
      wrsp = s_axi_bresp_out;
   endtask
   task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] e);
      @(posedge clock_in);
      s_axi_araddr_in  <= ad;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in  <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      s_axi_rready_in <= 1'b0;
      rsp = s_axi_rresp_out;
      chk(nm, s_axi_rdata_out, e);
   endtask
   // Settle time covers pin sync plus a pulse fed back into the count
   task automatic mv(input int n, input bit up, input int gap);
      ENC.move(n, up, gap);
      repeat (12) @(posedge clock_in);
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Clock and hang guard
   initial begin
      forever #2.5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ****************
   // Sequence
   // ****************
   initial begin
      repeat (12) @(posedge clock_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      rc("count", QEC_TIMER_OFS, 32'h0);
      chk("rresp", {30'h0, rsp}, {30'h0, QEC_RESP_OKAY});
      rc("unmapped", 8'h18, 32'h0);
      chk("resp", {30'h0, rsp}, {30'h0, QEC_RESP_SLVERR});
      wr(8'h18, 32'h1);
      chk("wresp", {30'h0, wrsp}, {30'h0, QEC_RESP_SLVERR});
      rc("ctrl", QEC_CTRL_OFS, 32'h0);
      wr(QEC_TIMER_OFS, 32'hfffd);
      chk("wresp", {30'h0, wrsp}, {30'h0, QEC_RESP_OKAY});
      rc("count", QEC_TIMER_OFS, 32'hfffd);
      rc("reload", QEC_RELOAD_OFS, 32'hfffd);
      wr(QEC_MASK_OFS, 32'h3);
      wr(QEC_CTRL_OFS, 32'h1);
      mv(8, 1, 4);
      rc("count", QEC_TIMER_OFS, 32'hffff);
      wr(QEC_TIMER_OFS, 32'h0010);
      rc("count", QEC_TIMER_OFS, 32'hffff);
      rc("reload", QEC_RELOAD_OFS, 32'h0010);
      mv(4, 1, 4);
      rc("count", QEC_TIMER_OFS, 32'h0010);
      chk("irq", {31'h0, irq_out}, 32'h1);
      chk("pin", {31'h0, timer_phase_b_out_pin_out}, 32'h0);
      rc("status", QEC_STATUS_OFS, 32'h1);
      wr(QEC_STATUS_OFS, 32'h1);
      chk("irq", {31'h0, irq_out}, 32'h0);
      mv(4, 0, 4);
      rc("count", QEC_TIMER_OFS, 32'h000f);
      wr(QEC_CTRL_OFS, 32'h5);
      mv(9, 1, 4);
      rc("count", QEC_TIMER_OFS, 32'h0018);
      rc("state", QEC_STATE_OFS, 32'hd);
      mv(3, 0, 12);
      rc("count", QEC_TIMER_OFS, 32'h0015);
      rc("state", QEC_STATE_OFS, 32'h4);
      wr(QEC_CTRL_OFS, 32'h0);
      wr(QEC_TIMER_OFS, 32'h0);
      wr(QEC_CTRL_OFS, 32'hf);
      wr(QEC_TIMER_OFS, 32'h0055);
      mv(1, 1, 4);
      rc("count", QEC_TIMER_OFS, 32'hfffe);
      chk("pin", {31'h0, timer_phase_b_out_pin_out}, 32'h1);
      rc("status", QEC_STATUS_OFS, 32'h2);
      wr(QEC_CTRL_OFS, 32'h0);
      mv(4, 1, 4);
      rc("count", QEC_TIMER_OFS, 32'hfffe);
      wr(QEC_MASK_OFS, 32'h0);
      chk("irq", {31'h0, irq_out}, 32'h0);
      wr(QEC_STATUS_OFS, 32'h2);
      rc("status", QEC_STATUS_OFS, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
